// [include/clkctl_map.svh]
// Purpose: field positions, reset values and rates for clock control
// Assumes: 100 MHz system clock, 24 MHz crystal, PLL multiply of 20
// Notes:   rates in MHz; divider halves are counted in PLL periods
`ifndef CLKCTL_MAP_SVH
`define CLKCTL_MAP_SVH

// ****************************************************************
// rates
// ****************************************************************
`define CC_CLK_MHZ 100
`define CC_OSC_MHZ 24
`define CC_PLL_MUL 20
`define CC_PLL_MHZ (`CC_OSC_MHZ * `CC_PLL_MUL)
`define CC_CORE_MHZ_12 12
`define CC_CORE_MHZ_24 24
`define CC_CORE_MHZ_48 48
`define CC_HALF_12 (`CC_PLL_MHZ / (2 * `CC_CORE_MHZ_12))
`define CC_HALF_24 (`CC_PLL_MHZ / (2 * `CC_CORE_MHZ_24))
`define CC_HALF_48 (`CC_PLL_MHZ / (2 * `CC_CORE_MHZ_48))
`define CC_ACC_DEN 10
`define CC_ACC_STEP (`CC_PLL_MHZ * `CC_ACC_DEN / `CC_CLK_MHZ)
`define CC_INSN_CLKS 4

// ****************************************************************
// cpu_control_reg fields
// ****************************************************************
`define CC_SEL_LSB 3
`define CC_SEL_MSB 4
`define CC_INV_BIT 2
`define CC_OE_BIT 1
`define CC_SEL_12 2'h0
`define CC_SEL_24 2'h1
`define CC_SEL_48 2'h2
`define CC_SEL_RSV 2'h3
`define CC_CTRL_RESET 8'h02

`endif

// [include/clkctl_pkg.sv]
// Purpose: types shared by the clock control modules
// Assumes: clkctl_map.svh holds every number
// Notes:   one packed state struct per module
package clkctl_pkg;

    typedef enum logic {CK_LOW, CK_HIGH} core_lvl_e;

    typedef struct packed {
        logic [3:0] frac;
        logic [2:0] edges;
    } pll_s;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [1:0] act_sel;
        logic [5:0] cnt;
        core_lvl_e lvl;
        logic [1:0] icnt;
        logic core;
        logic insn;
        logic pin_o;
        logic pin_oe;
    } cc_s;

endpackage

// [src/cpu_clock_ctrl.sv]
// Purpose: CPU core clock divider and clock output pin control
// Assumes: control writes come from logic on CLK
// Notes:   core clock is modelled as a level refreshed on CLK
// Notes on behaviour
// - a PLL multiplies the 24 MHz oscillator to 480 MHz for USB
// - core clock comes from divider counters on the PLL, not the oscillator
// - core clock runs at exactly 48, 24 or 12 MHz
// - after reset the core clock runs at 12 MHz
// - writing cpu_control_reg changes the core clock rate without reset
// - clock output pin carries the core clock at 50% duty
// - control bits tri-state the clock pin and invert its polarity
// - one instruction cycle spans four core clock periods
`timescale 1ns/10ps
`include "clkctl_map.svh"

module cpu_clock_ctrl
    import clkctl_pkg::*;
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // cpu_control_reg write port
    input wire logic CPU_CTRL_WE,
    input wire logic [7:0] CPU_CTRL_WDATA,
    output logic [7:0] CPU_CTRL_RDATA,
    // core clock
    output logic CORE_CLK,
    output logic INSN_STROBE,
    // core_clock_output_pin
    output logic CORE_CLK_PIN_O,
    output logic CORE_CLK_PIN_OE
);

    // ****************************************************************
    // state
    // ****************************************************************
    cc_s r, nxt;
    logic [2:0] edges;
    logic [6:0] sum;
    logic tog;
    // reset image of cpu_control_reg, only its OE bit read in the reset branch
    localparam logic [7:0] ctrl_rst = `CC_CTRL_RESET;

    function automatic logic [5:0] half_of(input logic [1:0] sel);
        case (sel)
            `CC_SEL_48: half_of = 6'(`CC_HALF_48);
            `CC_SEL_24: half_of = 6'(`CC_HALF_24);
            default: half_of = 6'(`CC_HALF_12);
        endcase
    endfunction

    pll_edges u_pll (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .edges(edges)
    );

    // ****************************************************************
    // divider and pin
    // ****************************************************************
    always_comb begin
        nxt = r;
        nxt.insn = 1'b0;
        if (CPU_CTRL_WE) begin
            nxt.ctrl = CPU_CTRL_WDATA;
            if (CPU_CTRL_WDATA[`CC_SEL_MSB:`CC_SEL_LSB] == `CC_SEL_RSV) begin
                // reserved rate code keeps the old rate
                nxt.ctrl[`CC_SEL_MSB:`CC_SEL_LSB] =
                    r.ctrl[`CC_SEL_MSB:`CC_SEL_LSB];
            end
        end
        sum = 7'(r.cnt) + 7'(edges);
        tog = 1'b0;
        if (sum >= 7'(half_of(r.act_sel))) begin
            sum = sum - 7'(half_of(r.act_sel));
            tog = 1'b1;
        end
        nxt.cnt = 6'(sum);
        if (tog) begin
            case (r.lvl)
                CK_LOW: begin
                    nxt.lvl = CK_HIGH;
                    nxt.icnt = r.icnt + 2'h1;
                    nxt.insn = (r.icnt == 2'(`CC_INSN_CLKS - 1));
                end
                CK_HIGH: begin
                    nxt.lvl = CK_LOW;
                    // rate changes only at a period end, so no runt pulse
                    nxt.act_sel = nxt.ctrl[`CC_SEL_MSB:`CC_SEL_LSB];
                    if (nxt.act_sel != r.act_sel) begin
                        // old remainder would burst fast toggles
                        nxt.cnt = '0;
                    end
                end
                default: nxt.lvl = CK_LOW;
            endcase
        end
        nxt.core = (nxt.lvl == CK_HIGH);
        nxt.pin_o = nxt.core ^ nxt.ctrl[`CC_INV_BIT];
        nxt.pin_oe = nxt.ctrl[`CC_OE_BIT];
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
            r.ctrl <= `CC_CTRL_RESET;
            r.act_sel <= `CC_SEL_12;
            r.lvl <= CK_LOW;
            r.pin_oe <= ctrl_rst[`CC_OE_BIT];
        end else if (CE) begin
            r <= nxt;
        end
    end

    assign CPU_CTRL_RDATA = r.ctrl;
    assign CORE_CLK = r.core;
    assign INSN_STROBE = r.insn;
    assign CORE_CLK_PIN_O = r.pin_o;
    assign CORE_CLK_PIN_OE = r.pin_oe;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic wrote_r;
    logic [2:0] stab_r;
    logic [2:0] rises_r;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wrote_r <= 1'b0;
            // first cycle after reset sees no pll periods, so not counted
            stab_r <= 3'h7;
            rises_r <= 3'h0;
        end else if (CE) begin
            wrote_r <= wrote_r | CPU_CTRL_WE;
            stab_r <= (nxt.core != r.core) ? 3'h0 : stab_r + 3'h1;
            if (nxt.insn) begin
                rises_r <= 3'h0;
            end else if (nxt.core && !r.core) begin
                rises_r <= rises_r + 3'h1;
            end
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence core_rise_s;
        CE && nxt.core && !r.core;
    endsequence

    sequence insn_fire_s;
        CE && nxt.insn;
    endsequence

    sequence write_s;
        CE && CPU_CTRL_WE;
    endsequence

    reset_rate_a: assert property (!wrote_r |-> r.act_sel == `CC_SEL_12)
        else $error("core rate left 12 MHz without a write");

    rate_legal_a: assert property (r.act_sel != `CC_SEL_RSV)
        else $error("reserved core rate in use");

    write_takes_a: assert property (
        CE && CPU_CTRL_WE &&
        CPU_CTRL_WDATA[`CC_SEL_MSB:`CC_SEL_LSB] != `CC_SEL_RSV
        |=> r.ctrl == $past(CPU_CTRL_WDATA))
        else $error("control write not stored");

    rate_switch_a: assert property (
        $past(CE) && $fell(r.core) && !$past(CPU_CTRL_WE)
        |-> r.act_sel == $past(r.ctrl[`CC_SEL_MSB:`CC_SEL_LSB]))
        else $error("rate not taken at period end");

    half_len_a: assert property (
        CE && nxt.core != r.core
        |-> 6'(stab_r) < ((half_of(r.act_sel) + 6'h3) >> 2))
        else $error("core clock phase too long");

    half_min_a: assert property (
        CE && nxt.core != r.core && $stable(r.act_sel)
        |-> 6'(stab_r) + 6'h2 >= half_of(r.act_sel) / 6'h5)
        else $error("core clock phase too short");

    pin_track_a: assert property (
        CE ##1 1'b1
        |-> CORE_CLK_PIN_O == (r.core ^ r.ctrl[`CC_INV_BIT])
            && CORE_CLK_PIN_OE == r.ctrl[`CC_OE_BIT])
        else $error("clock pin does not follow core clock");

    insn_four_a: assert property (
        insn_fire_s
        |-> (rises_r == 3'(`CC_INSN_CLKS - 1)) and core_rise_s)
        else $error("instruction cycle not four core clocks");

    // ****************************************************************
    // divider, strobe, control register and pin output checks
    // ****************************************************************
    cnt_bound_a: assert property (r.cnt < half_of(r.act_sel))
        else $error("divider remainder at or above half period");

    rate_hold_a: assert property (
        CE && !(r.core && !nxt.core) |=> $stable(r.act_sel))
        else $error("core rate changed inside a period");

    insn_pulse_a: assert property (
        CE && INSN_STROBE |=> !INSN_STROBE)
        else $error("instruction strobe longer than one cycle");

    rdata_hold_a: assert property (
        !(CE && CPU_CTRL_WE) |=> $stable(CPU_CTRL_RDATA))
        else $error("control register changed without a write");

    oe_write_a: assert property (
        write_s |=> CORE_CLK_PIN_OE == $past(CPU_CTRL_WDATA[`CC_OE_BIT]))
        else $error("pin enable not taken from the write");

    inv_write_a: assert property (
        write_s
        |=> CORE_CLK_PIN_O == (CORE_CLK ^ $past(CPU_CTRL_WDATA[`CC_INV_BIT])))
        else $error("pin polarity not taken from the write");

endmodule

// [src/pll_edges.sv]
// Purpose: counts PLL output periods elapsed in each system clock
// Assumes: PLL rate is 4.8 times the system clock
// Notes:   fractional remainder carried in tenths
`timescale 1ns/10ps
`include "clkctl_map.svh"

module pll_edges
    import clkctl_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // pll periods this cycle
    output logic [2:0] edges
);

    pll_s r, nxt;
    // remainder plus step reaches 57, so six bits are needed
    logic [5:0] total;

    always_comb begin
        nxt = r;
        total = 6'(r.frac) + 6'(`CC_ACC_STEP);
        nxt.edges = 3'(total / 6'(`CC_ACC_DEN));
        nxt.frac = 4'(total % 6'(`CC_ACC_DEN));
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= nxt;
        end
    end

    assign edges = r.edges;

    edge_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(ce) && $past(rst_n) |-> edges == 3'h4 || edges == 3'h5)
        else $error("pll period count out of range");

endmodule

// [verification/testbench.sv]
// Purpose: self-checking bench for the cpu core clock control block
// Assumes: core rate in MHz equals core periods per 100 CLK cycles
// Notes:   period and duty checks allow a couple of CLK of jitter
`timescale 1ns/10ps
`include "clkctl_map.svh"

module testbench;
    import clkctl_pkg::*;
    logic CLK, RST_N, CE, CPU_CTRL_WE;
    logic [7:0] CPU_CTRL_WDATA, ctrl_exp, w;
    wire [7:0] CPU_CTRL_RDATA;
    wire CORE_CLK, INSN_STROBE, CORE_CLK_PIN_O, CORE_CLK_PIN_OE;
    int err_total, samples_checked;
    logic [31:0] seed;
    logic [7:0] table_w [5] = '{8'h0A, 8'h16, 8'h1C, 8'h12, 8'h04};

    cpu_clock_ctrl cpu_clock_ctrl_i (.CLK(CLK), .RST_N(RST_N), .CE(CE),
        .CPU_CTRL_WE(CPU_CTRL_WE), .CPU_CTRL_WDATA(CPU_CTRL_WDATA),
        .CPU_CTRL_RDATA(CPU_CTRL_RDATA), .CORE_CLK(CORE_CLK),
        .INSN_STROBE(INSN_STROBE), .CORE_CLK_PIN_O(CORE_CLK_PIN_O),
        .CORE_CLK_PIN_OE(CORE_CLK_PIN_OE));

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] next_ctrl(input logic [7:0] o, d);
        if (d[4:3] == 2'h3) begin
            return {d[7:5], o[4:3], d[2:0]};
        end
        return d;
    endfunction

    task automatic tally_and_finish();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check8(input string n, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_span(input string n, input int lo, hi, g);
        samples_checked++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask

    task automatic step();
        @(posedge CLK);
        #1;
    endtask

    task automatic sync_rise();
        logic p;
        int k;
        p = CORE_CLK;
        for (k = 0; k < 200; k++) begin
            step();
            if (p === 1'b0 && CORE_CLK === 1'b1) begin
                return;
            end
            p = CORE_CLK;
        end
        err_total++;
        tally_and_finish();
    endtask

    task automatic write_ctrl(input logic [7:0] d);
        CPU_CTRL_WE = 1'b1;
        CPU_CTRL_WDATA = d;
        step();
        ctrl_exp = next_ctrl(ctrl_exp, d);
        check8("rdata", ctrl_exp, CPU_CTRL_RDATA);
    endtask

    // counts CLK cycles spanning rate-many core periods
    task automatic measure();
        int mhz, cyc, hi, rises, strobes;
        logic p, rise;
        mhz = (ctrl_exp[4:3] == 2'h0) ? 12 : (ctrl_exp[4:3] == 2'h1) ? 24 : 48;
        sync_rise();
        sync_rise();
        cyc = 0;
        hi = 0;
        rises = 0;
        strobes = 0;
        p = 1'b1;
        while (rises < mhz && cyc < 2000) begin
            step();
            cyc++;
            rise = !p && CORE_CLK;
            p = CORE_CLK;
            hi += int'(CORE_CLK === 1'b1);
            rises += int'(rise);
            check8("pin_o", {7'h0, CORE_CLK ^ ctrl_exp[2]}, {7'h0, CORE_CLK_PIN_O});
            check8("pin_oe", {7'h0, ctrl_exp[1]}, {7'h0, CORE_CLK_PIN_OE});
            if (INSN_STROBE === 1'b1) begin
                strobes++;
                check8("strobe_rise", 8'h01, {7'h0, rise});
            end
        end
        if (cyc >= 2000) begin
            err_total++;
            tally_and_finish();
        end
        check_span("period", 98, 102, cyc);
        check_span("duty", 47, 53, hi);
        check_span("strobes", mhz / 4, mhz / 4, strobes);
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        err_total = 0;
        samples_checked = 0;
        seed = 32'h0000_1244;
        RST_N = 1'b0;
        CE = 1'b1;
        CPU_CTRL_WE = 1'b0;
        CPU_CTRL_WDATA = 8'h00;
        for (int r = 0; r < 2; r++) begin
            repeat (8) step();
            check8("rst_rdata", 8'h02, CPU_CTRL_RDATA);
            check8("rst_oe", 8'h01, {7'h0, CORE_CLK_PIN_OE});
            RST_N = 1'b1;
            ctrl_exp = 8'h02;
            measure();
            foreach (table_w[i]) begin
                write_ctrl(table_w[i]);
                CPU_CTRL_WE = 1'b0;
                measure();
            end
            for (int i = 0; i < 4; i++) begin
                seed = xorshift(seed);
                write_ctrl(seed[7:0]);
            end
            CPU_CTRL_WE = 1'b0;
            measure();
            // a frozen block ignores writes and holds its clock
            CE = 1'b0;
            w = {7'h0, CORE_CLK};
            CPU_CTRL_WE = 1'b1;
            CPU_CTRL_WDATA = ctrl_exp ^ 8'h06;
            step();
            CPU_CTRL_WE = 1'b0;
            check8("frozen_rdata", ctrl_exp, CPU_CTRL_RDATA);
            repeat (20) begin
                step();
                check8("frozen", w, {7'h0, CORE_CLK});
                check8("frozen_oe", {7'h0, ctrl_exp[1]}, {7'h0, CORE_CLK_PIN_OE});
            end
            CE = 1'b1;
            RST_N = 1'b0;
        end
        tally_and_finish();
    end
endmodule
